/* design/asp_pkg.sv */
// Package for the four-mode asynchronous serial port
// Assumes a single 100 MHz peripheral clock and synchronous reset
package asp_pkg;

  // ****************************************
  // Modes and timing
  // ****************************************
  typedef enum logic [1:0] {
    ASP_MODE_SHIFT8 = 2'h0,
    ASP_MODE_UART8  = 2'h1,
    ASP_MODE_UART9F = 2'h2,
    ASP_MODE_UART9V = 2'h3
  } asp_mode_t;

  localparam int          CLK_PERIOD_NS   = 10;
  localparam logic [6:0]  DIV_SHIFT       = 7'h02;
  localparam logic [6:0]  DIV_FIXED_FAST  = 7'h20;
  localparam logic [6:0]  DIV_FIXED_SLOW  = 7'h40;
  localparam logic [3:0]  OVERSAMPLE      = 4'hf;
  localparam logic [3:0]  SAMPLE_POINT    = 4'h7;
  localparam logic [3:0]  BITS_8          = 4'h8;
  localparam logic [3:0]  BITS_9          = 4'h9;
  localparam logic [15:0] BRG_RELOAD_DEF  = 16'h0000;

endpackage

/* design/asp_tick_gen.sv */
// Bit-rate tick generator for the serial port
// Assumes the timer overflow input is a one-cycle pulse in the clk domain
`timescale 1ns/10ps
module asp_tick_gen
  import asp_pkg::*;
(
  input  wire logic        clk,          // Peripheral clock
  input  wire logic        reset,        // Sync reset, active high
  input  wire asp_pkg::asp_mode_t mode,  // Operating mode
  input  wire logic        smod,         // Mode 2 rate: 1 selects /32
  input  wire logic        use_timer,    // Variable rate from timer overflow
  input  wire logic [15:0] brg_reload,   // Baud generator reload value
  input  wire logic        timer_ovf,    // Timer overflow pulse
  output logic             tick          // Sixteenth-bit tick (bit tick in mode 0)
);
  import asp_pkg::*;

  logic [15:0] brg_reg;
  logic [6:0]  fix_reg;
  logic        brg_uf;
  logic [6:0]  fix_div;

  assign brg_uf  = (brg_reg == 16'h0000);
  assign fix_div = (mode == ASP_MODE_SHIFT8) ? DIV_SHIFT :
                   (smod ? (DIV_FIXED_FAST >> 4) : (DIV_FIXED_SLOW >> 4));

  // Dedicated baud generator counts down and reloads on underflow
  always_ff @(posedge clk) begin
    if (reset || brg_uf) begin
      brg_reg <= reset ? BRG_RELOAD_DEF : brg_reload;
    end else begin
      brg_reg <= brg_reg - 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || fix_reg >= fix_div - 7'h01) begin
      fix_reg <= 7'h00;
    end else begin
      fix_reg <= fix_reg + 7'h01;
    end
  end

  // Mode 0 and 2 fixed, modes 1 and 3 variable
  always_comb begin
    case (mode)
      ASP_MODE_SHIFT8, ASP_MODE_UART9F: tick = (fix_reg == fix_div - 7'h01);
      default:                          tick = use_timer ? timer_ovf : brg_uf;
    endcase
  end

  a_fixed_tick_gap: assert property (@(posedge clk) disable iff (reset)
    (mode == ASP_MODE_SHIFT8) && $stable(mode) && tick |=> !tick ##1 tick)
    else $error("mode 0 tick not every 2 clocks");

endmodule

/* design/asp_serial_port.sv */
// Four-mode asynchronous serial port: transmitter, buffered receiver
// Assumes rxd is already synchronous to clk and the rate source is stable
//
// Operation
// - Transmitter and receiver run independently for full duplex in modes 1 to 3; mode 0 only transmits.
// - Receiver assembles a new byte while the previous one waits unread.
// - A second byte completing before the first is read causes overrun.
// - Frames carry 8 or 9 data bits, least significant bit first.
// - Mode 0 is an 8-bit shift register at peripheral clock over 2.
// - Mode 1 is an 8-bit UART at a variable rate.
// - Mode 2 is a 9-bit UART at peripheral clock over 32 or 64.
// - Mode 3 is a 9-bit UART at a variable rate.
// - Variable rate comes from baud generator underflow or timer overflow.
// - A pulse is raised when transmission or reception completes.
// - Data arrives on the receive line and leaves on the transmit line in modes 1 to 3, on the receive line in mode 0.
`timescale 1ns/10ps
module asp_serial_port
  import asp_pkg::*;
(
  input  wire logic        clk,          // Peripheral clock, 100 MHz
  input  wire logic        reset,        // Sync reset, active high
  input  wire asp_pkg::asp_mode_t mode,  // Operating mode
  input  wire logic        smod,         // Mode 2: 1 selects /32, 0 selects /64
  input  wire logic        use_timer,    // Variable rate from timer overflow
  input  wire logic [15:0] brg_reload,   // Baud generator reload value
  input  wire logic        timer_ovf,    // Timer overflow pulse
  input  wire logic        addr_filter,  // Multiprocessor address filtering
  input  wire logic        rx_enable,    // Receiver enable
  input  wire logic        tx_start,     // Start a transmission (pulse)
  input  wire logic [8:0]  tx_data,      // Data to send, bit 8 used in 9-bit modes
  output logic             tx_busy,      // Transmitter busy
  input  wire logic        rx_read,      // Consume the receive register (pulse)
  output logic [8:0]       rx_data,      // Receive register
  output logic             rx_full,      // Receive register holds unread data
  output logic             rx_overrun,   // Overrun seen, sticky until read
  output logic             tx_done_irq,  // Transmission complete pulse
  output logic             rx_done_irq,  // Reception complete pulse
  input  wire logic        rxd_in,       // Receive line input
  output logic             rxd_out,      // Receive line drive (mode 0 data out)
  output logic             rxd_oe_n,     // Receive line enable, low drives
  output logic             txd           // Transmit line
);
  import asp_pkg::*;

  typedef enum logic [1:0] {ASP_IDLE, ASP_START, ASP_DATA, ASP_STOP} asp_state_t;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [3:0] frame_bits(input asp_mode_t m);
    frame_bits = (m == ASP_MODE_UART9F || m == ASP_MODE_UART9V) ?
                 BITS_9 : BITS_8;
  endfunction

  logic tick;
  logic is_sync;
  assign is_sync = (mode == ASP_MODE_SHIFT8);

  asp_tick_gen u_tick (
    .clk        (clk),
    .reset      (reset),
    .mode       (mode),
    .smod       (smod),
    .use_timer  (use_timer),
    .brg_reload (brg_reload),
    .timer_ovf  (timer_ovf),
    .tick       (tick)
  );

  // ****************************************
  // Transmitter
  // ****************************************
  asp_state_t  tx_state_reg;
  logic [8:0]  tx_shift_reg;
  logic [3:0]  tx_cnt_reg;
  logic [3:0]  tx_sub_reg;
  logic        tx_bit_tick;
  logic        txd_reg;
  logic        rx_mode0_drive_reg;

  // Mode 0 bit tick is the raw tick, async modes divide by 16
  assign tx_bit_tick = tick && (is_sync || tx_sub_reg == OVERSAMPLE);
  assign tx_busy     = (tx_state_reg != ASP_IDLE);

  always_ff @(posedge clk) begin
    if (reset || tx_state_reg == ASP_IDLE) begin
      tx_sub_reg <= 4'h0;
    end else if (tick) begin
      tx_sub_reg <= tx_sub_reg + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      tx_state_reg <= ASP_IDLE;
      tx_shift_reg <= 9'h000;
      tx_cnt_reg   <= 4'h0;
      txd_reg      <= 1'b1;
      tx_done_irq  <= 1'b0;
      rx_mode0_drive_reg <= 1'b0;
    end else begin
      tx_done_irq <= 1'b0;
      case (tx_state_reg)
        ASP_IDLE: begin
          txd_reg <= 1'b1;
          rx_mode0_drive_reg <= 1'b0;
          if (tx_start) begin
            tx_shift_reg <= tx_data;
            tx_cnt_reg   <= 4'h0;
            // Mode 0 waits for a tick too, so bit 0 lasts a full period
            tx_state_reg <= ASP_START;
            rx_mode0_drive_reg <= is_sync;
          end
        end
        ASP_START: begin
          txd_reg <= is_sync;
          if (tx_bit_tick) begin
            tx_state_reg <= ASP_DATA;
          end
        end
        ASP_DATA: begin
          // In mode 0 txd carries the shift clock, data goes on rxd
          txd_reg <= is_sync ? tx_cnt_reg[0] : tx_shift_reg[0];
          if (tx_bit_tick) begin
            tx_shift_reg <= {1'b0, tx_shift_reg[8:1]};
            tx_cnt_reg   <= tx_cnt_reg + 4'h1;
            if (tx_cnt_reg == frame_bits(mode) - 4'h1) begin
              tx_state_reg <= is_sync ? ASP_IDLE : ASP_STOP;
              tx_done_irq  <= is_sync;
            end
          end
        end
        ASP_STOP: begin
          txd_reg <= 1'b1;
          if (tx_bit_tick) begin
            tx_state_reg <= ASP_IDLE;
            tx_done_irq  <= 1'b1;
          end
        end
        default: tx_state_reg <= ASP_IDLE;
      endcase
    end
  end

  assign txd      = txd_reg;
  assign rxd_out  = tx_shift_reg[0];
  assign rxd_oe_n = ~rx_mode0_drive_reg;

  // ****************************************
  // Receiver (async modes), runs beside the transmitter
  // ****************************************
  asp_state_t  rx_state_reg;
  logic [8:0]  rx_shift_reg;
  logic [3:0]  rx_cnt_reg;
  logic [3:0]  rx_sub_reg;
  logic        rx_sample;
  logic        rx_done_next;
  logic [8:0]  rx_word_next;
  logic        rx_prev_reg;

  assign rx_sample = tick && (rx_sub_reg == SAMPLE_POINT);

  always_ff @(posedge clk) begin
    if (reset) begin
      rx_prev_reg <= 1'b1;
    end else begin
      rx_prev_reg <= rxd_in;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || rx_state_reg == ASP_IDLE) begin
      rx_sub_reg <= 4'h0;
    end else if (tick) begin
      rx_sub_reg <= rx_sub_reg + 4'h1;
    end
  end

  // The 8-bit frame lands right-aligned, ninth bit shifts in on top
  always_comb begin
    rx_word_next = (frame_bits(mode) == BITS_9) ? rx_shift_reg : {1'b0, rx_shift_reg[8:1]};
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rx_state_reg <= ASP_IDLE;
      rx_shift_reg <= 9'h000;
      rx_cnt_reg   <= 4'h0;
      rx_done_next <= 1'b0;
    end else begin
      rx_done_next <= 1'b0;
      case (rx_state_reg)
        ASP_IDLE: begin
          // Falling edge on an idle-high line marks a start bit
          if (rx_enable && !is_sync && rx_prev_reg && !rxd_in) begin
            rx_state_reg <= ASP_START;
          end
        end
        ASP_START: begin
          if (rx_sample) begin
            // A start bit gone high again was a glitch
            rx_state_reg <= rxd_in ? ASP_IDLE : ASP_DATA;
            rx_cnt_reg   <= 4'h0;
          end
        end
        ASP_DATA: begin
          if (rx_sample) begin
            rx_shift_reg <= {rxd_in, rx_shift_reg[8:1]};
            rx_cnt_reg   <= rx_cnt_reg + 4'h1;
            if (rx_cnt_reg == frame_bits(mode) - 4'h1) begin
              rx_state_reg <= ASP_STOP;
            end
          end
        end
        ASP_STOP: begin
          if (rx_sample) begin
            rx_state_reg <= ASP_IDLE;
            // Frames with a low stop bit are dropped as framing errors
            rx_done_next <= rxd_in;
          end
        end
        default: rx_state_reg <= ASP_IDLE;
      endcase
    end
  end

  // ****************************************
  // Receive register, overrun and address filter
  // ****************************************
  logic rx_accept;
  logic [8:0] rx_hold_reg;
  // Ninth bit is set in both layouts at bit 8 for 9-bit modes
  assign rx_accept = rx_done_next &&
                     !(addr_filter && frame_bits(mode) == BITS_9 && !rx_hold_reg[8]);

  always_ff @(posedge clk) begin
    if (reset) begin
      rx_hold_reg <= 9'h000;
    end else if (rx_state_reg == ASP_STOP && rx_sample) begin
      rx_hold_reg <= rx_word_next;
    end
  end

  // Old unread byte is kept, the new one is lost
  always_ff @(posedge clk) begin
    if (reset) begin
      rx_data    <= 9'h000;
      rx_full    <= 1'b0;
      rx_overrun <= 1'b0;
    end else begin
      // A read in the same cycle frees the register for the new byte
      if (rx_accept && (!rx_full || rx_read)) begin
        rx_data <= rx_hold_reg;
      end
      if (rx_accept) begin
        rx_full <= 1'b1;
      end else if (rx_read) begin
        rx_full <= 1'b0;
      end
      if (rx_accept && rx_full && !rx_read) begin
        rx_overrun <= 1'b1;
      end else if (rx_read) begin
        rx_overrun <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rx_done_irq <= 1'b0;
    end else begin
      rx_done_irq <= rx_accept;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_overrun_sets: assert property (@(posedge clk) disable iff (reset)
    rx_accept && rx_full && !rx_read |=> rx_overrun)
    else $error("overrun not flagged");

  a_rx_irq_follows: assert property (@(posedge clk) disable iff (reset)
    rx_accept |=> rx_done_irq && rx_full)
    else $error("rx done pulse missing");

  a_tx_irq_idle: assert property (@(posedge clk) disable iff (reset)
    tx_done_irq |-> !tx_busy && $past(tx_busy))
    else $error("tx done without end of frame");

  a_stop_high: assert property (@(posedge clk) disable iff (reset)
    tx_state_reg == ASP_STOP ##1 tx_state_reg == ASP_STOP |-> txd)
    else $error("stop bit not high");

  a_idle_high: assert property (@(posedge clk) disable iff (reset)
    $past(tx_state_reg) == ASP_IDLE && tx_state_reg == ASP_IDLE |-> txd)
    else $error("line not idle high");

  a_addr_filter: assert property (@(posedge clk) disable iff (reset)
    rx_done_next && addr_filter && frame_bits(mode) == BITS_9 && !rx_hold_reg[8]
    |=> !rx_done_irq)
    else $error("data frame passed address filter");

  a_keep_unread: assert property (@(posedge clk) disable iff (reset)
    rx_full && !rx_read |=> rx_data == $past(rx_data))
    else $error("unread byte overwritten");

  a_lsb_first: assert property (@(posedge clk) disable iff (reset)
    tx_state_reg == ASP_DATA && !is_sync && $past(tx_state_reg) == ASP_DATA
    |-> txd == $past(tx_shift_reg[0]))
    else $error("tx not lsb first");

endmodule

/* sim/asp_remote_node.sv */
// Remote asynchronous serial node facing the port's serial lines
// Assumes the bench feeds it clk and the bit period in clk cycles
`timescale 1ns/10ps
module asp_remote_node (
  input  wire logic clk,  // Peripheral clock
  input  wire logic txd,  // Device transmit line, listened to here
  output logic      rxd   // Drive toward the device receive line
);
  // ****************************************
  // Frame sender and frame listener
  // ****************************************
  initial rxd = 1'b1;  // Idle high between frames

  // Sends LSB first; stp lets a scenario break the stop bit on purpose
  task automatic send(input logic [8:0] d, input int nb, input int bc, input logic stp);
    int i;
    @(negedge clk);
    rxd = 1'b0;
    repeat (bc) @(negedge clk);
    for (i = 0; i < nb; i++) begin
      rxd = d[i];
      repeat (bc) @(negedge clk);
    end
    rxd = stp;
    repeat (bc) @(negedge clk);
    rxd = 1'b1;
  endtask

  // Samples mid-bit; returns at the middle of the stop bit
  task automatic recv(input int nb, input int bc, output logic [8:0] d, output logic ok);
    int i;
    int w;
    d  = '0;
    w  = 0;
    while (txd !== 1'b0 && w < 4000) begin
      @(negedge clk);
      w++;
    end
    ok = (w < 4000);
    repeat (bc / 2) @(negedge clk);
    if (txd !== 1'b0) ok = 1'b0;
    for (i = 0; i < nb; i++) begin
      repeat (bc) @(negedge clk);
      d[i] = txd;
    end
    repeat (bc) @(negedge clk);
    if (txd !== 1'b1) ok = 1'b0;
  endtask
endmodule

/* sim/asp_serial_port_tb.sv */
// Self-checking bench for the four-mode serial port
// Assumes the remote node model and the design package are compiled first
`timescale 1ns/10ps
module asp_serial_port_tb;
  import asp_pkg::*;
  // ****************************************
  // Stimulus, monitors and scenarios
  // ****************************************
  logic clk, reset, smod, use_timer, addr_filter, rx_enable, tx_start, rx_read;
  logic        timer_ovf = 1'b0;
  logic tx_busy, rx_full, rx_overrun, tx_done_irq, rx_done_irq, rxd_out, rxd_oe_n, txd;
  logic node_rxd, rxd_line;
  logic [15:0] brg_reload;
  logic [8:0]  tx_data, rx_data;
  logic [1:0]  tdiv = 2'h0;
  asp_mode_t   mode;
  int          errors, n_compared, n_tx, n_rx;

  assign rxd_line = rxd_oe_n ? node_rxd : rxd_out;  // Shared receive pin

  asp_serial_port i_dut (.clk(clk), .reset(reset), .mode(mode), .smod(smod),
    .use_timer(use_timer), .brg_reload(brg_reload), .timer_ovf(timer_ovf),
    .addr_filter(addr_filter), .rx_enable(rx_enable), .tx_start(tx_start),
    .tx_data(tx_data), .tx_busy(tx_busy), .rx_read(rx_read), .rx_data(rx_data),
    .rx_full(rx_full), .rx_overrun(rx_overrun), .tx_done_irq(tx_done_irq),
    .rx_done_irq(rx_done_irq), .rxd_in(rxd_line), .rxd_out(rxd_out),
    .rxd_oe_n(rxd_oe_n), .txd(txd));
  asp_remote_node i_node (.clk(clk), .txd(txd), .rxd(node_rxd));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Timer runs always at 4 clk per tick, so a wrong rate source shows
  always @(negedge clk) begin
    tdiv      <= tdiv + 2'h1;
    timer_ovf <= (tdiv == 2'h3);
  end
  always @(negedge clk) begin
    if (tx_done_irq === 1'b1) n_tx++;
    if (rx_done_irq === 1'b1) n_rx++;
  end

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic pulse_read();
    @(negedge clk) rx_read = 1'b1;
    @(negedge clk) rx_read = 1'b0;
  endtask
  // Transmit and receive at once, then judge both directions
  task automatic xfer(input logic [8:0] td, input logic [8:0] rd, input int nb, input int bc);
    logic [8:0] got;
    logic ok;
    int t0, r0, w;
    t0 = n_tx;
    r0 = n_rx;
    fork
      i_node.recv(nb, bc, got, ok);
      i_node.send(rd, nb, bc, 1'b1);
      begin
        @(negedge clk);
        tx_data  = td;
        tx_start = 1'b1;
        @(negedge clk) tx_start = 1'b0;
      end
    join
    w = 0;
    while (tx_busy !== 1'b0 && w < 500) begin
      @(negedge clk);
      w++;
    end
    repeat (3) @(negedge clk);
    check("line_frame", 16'(ok), 16'h0001);
    check("tx_bits", 16'(got), 16'(td));
    check("rx_data", 16'(rx_data), 16'(rd));
    check("tx_irqs", 16'(n_tx - t0), 16'h0001);
    check("rx_irqs", 16'(n_rx - r0), 16'h0001);
    pulse_read();
  endtask

  task automatic t_mode1();
    mode       = ASP_MODE_UART8;
    use_timer  = 1'b0;
    brg_reload = 16'h0001;
    xfer(9'h03c, 9'h0a5, 8, 32);
    $display("mode 1 full duplex done");
  endtask
  task automatic t_mode3();
    mode       = ASP_MODE_UART9V;
    use_timer  = 1'b1;
    brg_reload = 16'h0000;
    xfer(9'h1c3, 9'h15a, 9, 64);
    $display("mode 3 timer rate done");
  endtask
  task automatic t_mode2();
    mode = ASP_MODE_UART9F;
    smod = 1'b1;
    xfer(9'h0f1, 9'h10e, 9, 32);
    smod = 1'b0;
    xfer(9'h12d, 9'h0d2, 9, 64);
    $display("mode 2 fixed rates done");
  endtask
  task automatic t_overrun();
    mode       = ASP_MODE_UART8;
    use_timer  = 1'b0;
    brg_reload = 16'h0001;
    i_node.send(9'h011, 8, 32, 1'b1);
    i_node.send(9'h022, 8, 32, 1'b1);
    repeat (4) @(negedge clk);
    check("overrun", 16'(rx_overrun), 16'h0001);
    check("kept_byte", 16'(rx_data), 16'h0011);
    pulse_read();
    check("full_clr", 16'({rx_full, rx_overrun}), 16'h0000);
    $display("overrun done");
  endtask
  task automatic t_filter();
    int r0;
    mode        = ASP_MODE_UART9V;
    use_timer   = 1'b1;
    addr_filter = 1'b1;
    r0          = n_rx;
    i_node.send(9'h055, 9, 64, 1'b1);
    repeat (4) @(negedge clk);
    check("data_frame", 16'({rx_full, 8'(n_rx - r0)}), 16'h0000);
    i_node.send(9'h1a3, 9, 64, 1'b1);
    repeat (4) @(negedge clk);
    check("addr_frame", 16'(rx_data), 16'h01a3);
    check("addr_irq", 16'(n_rx - r0), 16'h0001);
    pulse_read();
    addr_filter = 1'b0;
    r0          = n_rx;
    i_node.send(9'h0aa, 9, 64, 1'b0);
    repeat (4) @(negedge clk);
    check("bad_stop", 16'({rx_full, 8'(n_rx - r0)}), 16'h0000);
    rx_enable = 1'b0;
    i_node.send(9'h1aa, 9, 64, 1'b1);
    repeat (4) @(negedge clk);
    check("rx_off", 16'({rx_full, 8'(n_rx - r0)}), 16'h0000);
    rx_enable = 1'b1;
    $display("address filter done");
  endtask
  // Last scenario: shift mode leaves txd as a clock level
  task automatic t_mode0();
    logic [7:0] bits;
    logic lt, oe_seen;
    int k, gap, badgap, w;
    mode = ASP_MODE_SHIFT8;
    {bits, oe_seen, k, gap, badgap, w} = '0;
    @(negedge clk);
    tx_data  = 9'h0b4;
    tx_start = 1'b1;
    @(negedge clk) tx_start = 1'b0;
    lt = txd;
    while (tx_busy !== 1'b0 && w < 100) begin
      @(negedge clk);
      w++;
      gap++;
      if (rxd_oe_n === 1'b0) oe_seen = 1'b1;
      if (txd !== lt) begin
        if (k < 8) bits[k] = rxd_out;
        if (k > 0 && gap != 2) badgap++;
        k++;
        gap = 0;
        lt  = txd;
      end
    end
    check("shift_bits", 16'(bits), 16'h00b4);
    check("shift_rate", 16'(badgap), 16'h0000);
    check("shift_drive", 16'(oe_seen), 16'h0001);
    check("shift_end", 16'(tx_busy), 16'h0000);
    $display("mode 0 shift done");
  endtask

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    tally_and_finish();
  end
  initial begin
    {reset, smod, use_timer, addr_filter, tx_start, rx_read} = 6'h20;
    {errors, n_compared, n_tx, n_rx} = '0;
    rx_enable  = 1'b1;
    brg_reload = 16'h0001;
    tx_data    = 9'h000;
    mode       = ASP_MODE_UART8;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    check("reset_out", 16'({txd, tx_busy, rx_full, rxd_oe_n}), 16'h0009);
    t_mode1();
    t_mode3();
    t_mode2();
    t_overrun();
    t_filter();
    t_mode0();
    tally_and_finish();
  end
endmodule
